//--- rtl/lss_link_slot_regs.sv
// Link status upper half and slot capabilities register bank on APB
//
// Function
// RULE1: Training flag set in Configuration, Recovery, pending retrain
// RULE2: Training flag clears when those states exit
// RULE3: Training flag reads zero unless downstream port
// RULE4: Common-clock bit strapped, writable only unlocked
// RULE5: Bit 13 mirrors data link active state
// RULE6: Link-active never set without reporting capability
// RULE7: Bandwidth flag on retrain done, reliability change
// RULE8: Bandwidth flag on non-autonomous downstream change
// RULE9: Autonomous flag on other changes; write-one clears
// RULE10: Both flags zero without notify capability, upstream
// RULE11: Slot fields read zero without slot implemented
// RULE12: Bits 0..6 advertise hot-plug hardware, reset zero
// RULE13: Bits 14:7 give power limit value
// RULE14: Bits 16:15 give power limit scale
// RULE15: Power limit message on write, DL_Up entry
// RULE16: Bit 17 advertises electromechanical interlock
// RULE17: Bit 18 hardwired to zero
// RULE18: Software programs physical slot number bits 31:19
// RULE19: Lockable fields writable only while unlocked
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "lss_consts.svh"
module lss_link_slot_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire lss_pkg::lss_apb_req_t apb_req,
    output lss_pkg::lss_apb_rsp_t apb_rsp,
    input wire lss_pkg::lss_ltssm_t ltssm_state,
    input wire logic retrain_request,
    input wire lss_pkg::lss_port_mode_t port_mode,
    input wire logic common_clock_strap,
    input wire logic data_link_active,
    input wire logic dl_active_report_capable,
    input wire logic bandwidth_notify_capable,
    input wire logic slot_implemented,
    input wire lss_pkg::lss_bw_evt_t bw_evt,
    input wire logic msg_ready,
    output lss_pkg::lss_spl_msg_t spl_msg,
    output logic training_in_progress,
    output logic irq
);
    import lss_pkg::*;

    typedef struct packed {
        lss_apb_rsp_t rsp;
        logic strap_done;
        logic common_clock;
        logic dl_active;
        logic link_up;
        logic bw_mgmt;
        logic bw_auto;
        logic [31:0] scap;
        logic lock;
        logic [`LSS_IRQ_W-1:0] irq_stat;
        logic [`LSS_IRQ_W-1:0] irq_en;
        logic irq;
        logic scap_wr;
    } lss_regs_state_t;

    lss_regs_state_t st_r;
    lss_regs_state_t st_nxt;
    logic train_w;
    logic wr_acc;
    logic rd_acc;
    logic flags_ok;
    logic set_bwm;
    logic set_abw;
    logic [15:0] lsts_hi;
    logic [31:0] scap_view;
    logic [31:0] wd;
    logic [`LSS_IRQ_W-1:0] evt;

    // Lockable bits: capability flags, interlock, slot number
    function automatic logic [31:0] lockable_mask();
        logic [31:0] m;
        m = '0;
        m[`LSS_SC_FLAGS_HI:0] = '1;
        m[`LSS_SC_EIP] = 1'b1;
        m[`LSS_SC_PSN_HI:`LSS_SC_PSN_LO] = '1;
        return m;
    endfunction : lockable_mask

    // Power limit fields, writable whether locked or not
    function automatic logic [31:0] plain_mask();
        logic [31:0] m;
        m = '0;
        m[`LSS_SC_PLS_HI:`LSS_SC_PLV_LO] = '1;
        return m;
    endfunction : plain_mask

    // Register map decode, used only by the error path; the read path has its own case
    function automatic logic addr_known(input logic [11:0] a);
        logic hit;
        hit = 1'b0;
        case (a)
            `LSS_OFF_LSTS,
            `LSS_OFF_SCAP,
            `LSS_OFF_CTRL,
            `LSS_OFF_IRQ_STAT,
            `LSS_OFF_IRQ_EN,
            `LSS_OFF_IRQ_CLR: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction : addr_known

    lss_train_track u_train (
        .pclk(pclk),
        .presetn(presetn),
        .ltssm_state(ltssm_state),
        .retrain_request(retrain_request),
        .port_mode(port_mode),
        .training_in_progress(train_w)
    );

    lss_spl_msg u_msg (
        .pclk(pclk),
        .presetn(presetn),
        .scap_written(st_r.scap_wr),
        .dl_up(st_r.link_up),
        .value(scap_view[`LSS_SC_PLV_HI:`LSS_SC_PLV_LO]), // RULE13
        .scale(scap_view[`LSS_SC_PLS_HI:`LSS_SC_PLS_LO]), // RULE14
        .msg_ready(msg_ready),
        .msg(spl_msg)
    );

    always_comb begin
        st_nxt = st_r;
        wd = apb_req.pwdata;
        wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
        rd_acc = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
        flags_ok = bandwidth_notify_capable &&
                   (port_mode != LSS_PM_UPSTREAM); // RULE10
        set_bwm = flags_ok && (bw_evt.retrain_done ||
                  bw_evt.auto_reliability || // RULE7
                  (bw_evt.ds_change && !bw_evt.ds_autonomous)); // RULE8
        set_abw = flags_ok && (bw_evt.auto_other ||
                  (bw_evt.ds_change && bw_evt.ds_autonomous)); // RULE9
        scap_view = slot_implemented ? st_r.scap : '0; // RULE11
        scap_view[`LSS_SC_NO_CMD_COMPLETE_SUPPORT] = 1'b0; // RULE17

        lsts_hi = '0;
        lsts_hi[`LSS_B_TRAIN] = train_w; // RULE1
        lsts_hi[`LSS_B_SCLK] = st_r.common_clock;
        lsts_hi[`LSS_B_DLLA] = st_r.dl_active; // RULE5
        lsts_hi[`LSS_B_BWM] = st_r.bw_mgmt;
        lsts_hi[`LSS_B_ABW] = st_r.bw_auto;

        // Strap caught one cycle after reset release
        if (!st_r.strap_done) begin
            st_nxt.strap_done = 1'b1;
            st_nxt.common_clock = common_clock_strap; // RULE4
        end
        st_nxt.dl_active = data_link_active &&
                           dl_active_report_capable; // RULE5 RULE6
        // Message follows the real link, not the masked status bit
        st_nxt.link_up = data_link_active; // RULE15

        // Zero-wait slave: pready high during every access phase
        st_nxt.rsp.pready = apb_req.psel && !apb_req.penable;
        st_nxt.rsp.pslverr = 1'b0;
        st_nxt.scap_wr = 1'b0;
        if (apb_req.psel && !apb_req.penable) begin
            // Unmapped words answer with an error and read as zero
            st_nxt.rsp.pslverr = !addr_known(apb_req.paddr);
            st_nxt.rsp.prdata = '0;
        end
        if (rd_acc) begin
            case (apb_req.paddr)
                `LSS_OFF_LSTS: begin
                    st_nxt.rsp.prdata = {lsts_hi, 16'h0000};
                end
                `LSS_OFF_SCAP: begin
                    st_nxt.rsp.prdata = scap_view;
                end
                `LSS_OFF_CTRL: begin
                    st_nxt.rsp.prdata = 32'(st_r.lock);
                end
                `LSS_OFF_IRQ_STAT: begin
                    st_nxt.rsp.prdata = 32'(st_r.irq_stat);
                end
                `LSS_OFF_IRQ_EN: begin
                    st_nxt.rsp.prdata = 32'(st_r.irq_en);
                end
                default: begin
                    // Clear register is write-only, reads as zero
                    st_nxt.rsp.prdata = '0;
                end
            endcase
        end

        evt = '0;
        evt[`LSS_IRQ_BWM] = set_bwm;
        evt[`LSS_IRQ_ABW] = set_abw;
        evt[`LSS_IRQ_MSG] = spl_msg.valid && msg_ready;

        if (wr_acc) begin
            case (apb_req.paddr)
                `LSS_OFF_LSTS: begin
                    if (wd[`LSS_LSTS_SHIFT + `LSS_B_BWM]) begin
                        st_nxt.bw_mgmt = 1'b0; // RULE7
                    end
                    if (wd[`LSS_LSTS_SHIFT + `LSS_B_ABW]) begin
                        st_nxt.bw_auto = 1'b0; // RULE9
                    end
                    if (!st_r.lock) begin
                        st_nxt.common_clock =
                            wd[`LSS_LSTS_SHIFT + `LSS_B_SCLK]; // RULE4
                    end
                end
                `LSS_OFF_SCAP: begin
                    if (slot_implemented) begin // RULE11
                        st_nxt.scap_wr = 1'b1; // RULE15
                        st_nxt.scap = (st_r.scap & ~plain_mask()) |
                                      (wd & plain_mask());
                        if (!st_r.lock) begin
                            st_nxt.scap = (st_nxt.scap &
                                ~lockable_mask()) |
                                (wd & lockable_mask()); // RULE19 RULE12
                        end
                    end
                end
                `LSS_OFF_CTRL: begin
                    st_nxt.lock = wd[`LSS_CTRL_LOCK]; // RULE19
                end
                `LSS_OFF_IRQ_EN: begin
                    st_nxt.irq_en = wd[`LSS_IRQ_W-1:0];
                end
                `LSS_OFF_IRQ_CLR: begin
                    st_nxt.irq_stat =
                        st_r.irq_stat & ~wd[`LSS_IRQ_W-1:0];
                end
                default: begin
                    st_nxt.scap_wr = 1'b0;
                end
            endcase
        end
        st_nxt.scap[`LSS_SC_NO_CMD_COMPLETE_SUPPORT] = 1'b0; // RULE17

        // Hardware set wins over a same-cycle write-one clear
        if (set_bwm) begin
            st_nxt.bw_mgmt = 1'b1; // RULE7 RULE8
        end
        if (set_abw) begin
            st_nxt.bw_auto = 1'b1; // RULE9
        end
        if (!flags_ok) begin
            st_nxt.bw_mgmt = 1'b0; // RULE10
            st_nxt.bw_auto = 1'b0; // RULE10
        end
        st_nxt.irq_stat = st_nxt.irq_stat | evt;
        st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_en);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.scap <= `LSS_SCAP_RST; // RULE12 RULE16
        end else begin
            st_r <= st_nxt;
        end
    end

    assign apb_rsp = st_r.rsp;
    assign training_in_progress = train_w;
    assign irq = st_r.irq;
endmodule : lss_link_slot_regs

//--- include/lss_consts.svh
// Register offsets, field positions and reset values for the link/slot bank
`ifndef LSS_CONSTS_SVH
`define LSS_CONSTS_SVH
`define LSS_OFF_LSTS 12'h050
`define LSS_OFF_SCAP 12'h054
`define LSS_OFF_CTRL 12'h060
`define LSS_OFF_IRQ_STAT 12'h064
`define LSS_OFF_IRQ_EN 12'h068
`define LSS_OFF_IRQ_CLR 12'h06C
`define LSS_LSTS_SHIFT 16
`define LSS_B_TRAIN 11
`define LSS_B_SCLK 12
`define LSS_B_DLLA 13
`define LSS_B_BWM 14
`define LSS_B_ABW 15
`define LSS_SC_FLAGS_HI 6
`define LSS_SC_PLV_LO 7
`define LSS_SC_PLV_HI 14
`define LSS_SC_PLS_LO 15
`define LSS_SC_PLS_HI 16
`define LSS_SC_EIP 17
`define LSS_SC_NO_CMD_COMPLETE_SUPPORT 18
`define LSS_SC_PSN_LO 19
`define LSS_SC_PSN_HI 31
`define LSS_SCAP_RST 32'h0000_0000
`define LSS_CTRL_LOCK 0
`define LSS_IRQ_BWM 0
`define LSS_IRQ_ABW 1
`define LSS_IRQ_MSG 2
`define LSS_IRQ_W 3
`endif

//--- include/lss_pkg.sv
// Types shared by the link status and slot capability bank
package lss_pkg;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } lss_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } lss_apb_rsp_t;

    typedef enum logic [2:0] {
        LSS_LT_DETECT = 3'b000,
        LSS_LT_CONFIG = 3'b001,
        LSS_LT_L0 = 3'b011,
        LSS_LT_RECOVERY = 3'b010,
        LSS_LT_OTHER = 3'b110
    } lss_ltssm_t;

    typedef enum logic [1:0] {
        LSS_PM_DOWNSTREAM = 2'b00,
        LSS_PM_UPSTREAM = 2'b01,
        LSS_PM_OTHER = 2'b11
    } lss_port_mode_t;

    // Bandwidth change events reported by the physical layer
    typedef struct packed {
        logic retrain_done;
        logic auto_reliability;
        logic auto_other;
        logic ds_change;
        logic ds_autonomous;
    } lss_bw_evt_t;

    typedef struct packed {
        logic valid;
        logic [7:0] value;
        logic [1:0] scale;
    } lss_spl_msg_t;

    typedef enum logic [1:0] {
        LSS_MS_IDLE = 2'b00,
        LSS_MS_SEND = 2'b01
    } lss_msg_state_t;
endpackage : lss_pkg

//--- rtl/lss_train_track.sv
// Training-in-progress tracker
`timescale 1ns/10ps
`include "lss_consts.svh"
module lss_train_track (
    input wire logic pclk,
    input wire logic presetn,
    input wire lss_pkg::lss_ltssm_t ltssm_state,
    input wire logic retrain_request,
    input wire lss_pkg::lss_port_mode_t port_mode,
    output logic training_in_progress
);
    import lss_pkg::*;

    typedef struct packed {
        logic pending;
        logic busy;
    } lss_tt_state_t;

    lss_tt_state_t st_r;
    lss_tt_state_t st_nxt;
    logic in_train;

    always_comb begin
        in_train = (ltssm_state == LSS_LT_CONFIG) ||
                   (ltssm_state == LSS_LT_RECOVERY);
        st_nxt = st_r;
        // Pending retrain drops once training actually starts
        if (in_train) begin
            st_nxt.pending = 1'b0;
        end else if (retrain_request) begin
            st_nxt.pending = 1'b1; // RULE1
        end
        st_nxt.busy = (in_train || st_nxt.pending) && // RULE1 RULE2
                      (port_mode == LSS_PM_DOWNSTREAM); // RULE3
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign training_in_progress = st_r.busy;
endmodule : lss_train_track

//--- rtl/lss_spl_msg.sv
// Set_Slot_Power_Limit message request generator
`timescale 1ns/10ps
module lss_spl_msg (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic scap_written,
    input wire logic dl_up,
    input wire logic [7:0] value,
    input wire logic [1:0] scale,
    input wire logic msg_ready,
    output lss_pkg::lss_spl_msg_t msg
);
    import lss_pkg::*;

    typedef struct packed {
        lss_msg_state_t fsm;
        logic dl_up_d;
        logic again;
        lss_spl_msg_t msg;
    } lss_sm_state_t;

    lss_sm_state_t st_r;
    lss_sm_state_t st_nxt;
    logic trig;

    always_comb begin
        st_nxt = st_r;
        st_nxt.dl_up_d = dl_up;
        trig = scap_written || (dl_up && !st_r.dl_up_d); // RULE15
        case (st_r.fsm)
            LSS_MS_IDLE: begin
                if (trig) begin
                    st_nxt.fsm = LSS_MS_SEND;
                    st_nxt.msg = '{valid: 1'b1, value: value, scale: scale};
                end
            end
            LSS_MS_SEND: begin
                // A trigger while busy is remembered, not dropped
                if (trig) begin
                    st_nxt.again = 1'b1;
                end
                if (msg_ready) begin
                    st_nxt.msg.valid = 1'b0;
                    st_nxt.fsm = LSS_MS_IDLE;
                    if (trig || st_r.again) begin
                        st_nxt.again = 1'b0;
                        st_nxt.fsm = LSS_MS_SEND;
                        st_nxt.msg = '{valid: 1'b1, value: value,
                                       scale: scale}; // RULE15
                    end
                end
            end
            default: begin
                st_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign msg = st_r.msg;
endmodule : lss_spl_msg

//--- tb/lss_lsr_asserts.sv
// Port assertions for the link status and slot capability bank
`timescale 1ns/10ps
`include "lss_consts.svh"
module lss_lsr_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire lss_pkg::lss_apb_req_t apb_req,
    input wire lss_pkg::lss_apb_rsp_t apb_rsp,
    input wire lss_pkg::lss_ltssm_t ltssm_state,
    input wire lss_pkg::lss_port_mode_t port_mode,
    input wire logic dl_active_report_capable,
    input wire logic bandwidth_notify_capable,
    input wire logic slot_implemented,
    input wire logic msg_ready,
    input wire lss_pkg::lss_spl_msg_t spl_msg,
    input wire logic training_in_progress,
    input wire logic irq
);
    import lss_pkg::*;
    logic acc;
    logic rd_ls;
    logic rd_sc;
    assign acc = apb_req.psel & apb_req.penable & apb_rsp.pready;
    assign rd_ls = acc & ~apb_req.pwrite & (apb_req.paddr == `LSS_OFF_LSTS);
    assign rd_sc = acc & ~apb_req.pwrite & (apb_req.paddr == `LSS_OFF_SCAP);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_setup: assert property (apb_req.psel && !apb_req.penable
        |=> apb_rsp.pready) else $error("no ready after setup");
    a_train_set: assert property (
        port_mode == LSS_PM_DOWNSTREAM && (ltssm_state == LSS_LT_CONFIG
        || ltssm_state == LSS_LT_RECOVERY) |=> training_in_progress)
        else $error("training flag missing");
    a_train_mode: assert property (
        port_mode != LSS_PM_DOWNSTREAM |=> !training_in_progress)
        else $error("training flag outside downstream mode");
    a_dla_cap: assert property (
        !dl_active_report_capable [*4] ##0 rd_ls |-> !apb_rsp.prdata[29])
        else $error("link active without capability");
    a_bw_off: assert property (
        !bandwidth_notify_capable [*4] ##0 rd_ls
        |-> apb_rsp.prdata[31:30] == 2'h0) else $error("bw flag not zero");
    a_bw_upstream: assert property (
        (port_mode == LSS_PM_UPSTREAM) [*4] ##0 rd_ls
        |-> apb_rsp.prdata[31:30] == 2'h0) else $error("bw flag upstream");
    a_no_cmd_complete_support_zero: assert property (
        rd_sc |-> !apb_rsp.prdata[18]) else $error("bit 18 not zero");
    a_slot_off: assert property (
        !slot_implemented [*3] ##0 rd_sc |-> apb_rsp.prdata == 32'h0)
        else $error("slot fields not zero");
    a_msg_write: assert property (
        acc && apb_req.pwrite && apb_req.paddr == `LSS_OFF_SCAP
        && slot_implemented |-> ##[1:2] spl_msg.valid)
        else $error("no power limit message");
    a_msg_hold: assert property (
        spl_msg.valid && !msg_ready |=> spl_msg.valid)
        else $error("message dropped before ready");

    c_msg: cover property (spl_msg.valid && msg_ready);
    c_irq: cover property ($rose(irq));
    c_train: cover property ($fell(training_in_progress));
endmodule : lss_lsr_asserts

bind lss_link_slot_regs lss_lsr_asserts u_chk (.pclk, .presetn, .apb_req,
    .apb_rsp, .ltssm_state, .port_mode, .dl_active_report_capable,
    .bandwidth_notify_capable, .slot_implemented, .msg_ready, .spl_msg,
    .training_in_progress, .irq);

//--- tb/lss_link_slot_regs_tb_top.sv
// Self-checking bench for the link status and slot capability bank
`timescale 1ns/10ps
`include "lss_consts.svh"
module lss_link_slot_regs_tb_top;
    import lss_pkg::*;
    localparam logic [11:0] LS = `LSS_OFF_LSTS;
    localparam logic [11:0] SC = `LSS_OFF_SCAP;
    localparam logic [11:0] IS = `LSS_OFF_IRQ_STAT;
    localparam logic [11:0] IE = `LSS_OFF_IRQ_EN;
    localparam logic [11:0] IC = `LSS_OFF_IRQ_CLR;
    localparam lss_port_mode_t DS = LSS_PM_DOWNSTREAM;
    localparam lss_port_mode_t UP = LSS_PM_UPSTREAM;
    logic pclk, presetn, retrain_request, common_clock_strap;
    logic data_link_active, dl_active_report_capable;
    logic bandwidth_notify_capable, slot_implemented, msg_ready;
    logic training_in_progress, irq, rerr;
    logic [31:0] rdat;
    lss_apb_req_t apb_req;
    lss_apb_rsp_t apb_rsp;
    lss_ltssm_t ltssm_state;
    lss_port_mode_t port_mode;
    lss_bw_evt_t bw_evt;
    lss_spl_msg_t spl_msg;
    int mismatches = 0;
    int num_checks = 0;

    lss_link_slot_regs uut (.pclk, .presetn, .apb_req, .apb_rsp,
        .ltssm_state, .retrain_request, .port_mode, .common_clock_strap,
        .data_link_active, .dl_active_report_capable,
        .bandwidth_notify_capable, .slot_implemented, .bw_evt, .msg_ready,
        .spl_msg, .training_in_progress, .irq);

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // Outputs are read right after an edge, so they show edge values
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
                     pwdata: d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        check(32'(apb_rsp.pready), 32'h1);
        rdat = apb_rsp.prdata;
        rerr = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        check(rdat, exp);
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr

    task automatic wait_msg(input logic [9:0] exp);
        int n;
        n = 0;
        while (spl_msg.valid !== 1'b1 && n < 10) begin
            @(posedge pclk);
            n++;
        end
        check(32'(spl_msg.valid), 32'h1);
        check(32'({spl_msg.value, spl_msg.scale}), 32'(exp));
    endtask : wait_msg

    task automatic trn(input lss_ltssm_t s, input logic r,
                       input lss_port_mode_t m, input logic exp);
        ltssm_state <= s;
        retrain_request <= r;
        port_mode <= m;
        cyc(3);
        check(32'(training_in_progress), 32'(exp));
    endtask : trn

    task automatic pulse(input logic [4:0] e);
        bw_evt <= lss_bw_evt_t'(e);
        cyc(1);
        bw_evt <= '0;
        cyc(2);
    endtask : pulse

    task automatic bwt(input logic [4:0] e, input logic [1:0] f);
        pulse(e);
        rd(LS, 32'h2000_0000 | (32'(f) << 30));
        rd(IS, 32'(f));
        check(32'(irq), 32'h1);
        wr(LS, 32'hC000_0000);
        wr(IC, 32'h3);
        rd(LS, 32'h2000_0000);
        check(32'(irq), 32'h0);
    endtask : bwt

    initial begin
        logic [31:0] d;
        apb_req = '0;
        presetn = 1'b0;
        ltssm_state = LSS_LT_DETECT;
        retrain_request = 1'b0;
        port_mode = DS;
        common_clock_strap = 1'b1;
        data_link_active = 1'b0;
        dl_active_report_capable = 1'b1;
        bandwidth_notify_capable = 1'b1;
        slot_implemented = 1'b1;
        bw_evt = '0;
        msg_ready = 1'b0;
        cyc(10);
        presetn <= 1'b1;
        cyc(1);
        rd(LS, 32'h1000_0000);
        rd(SC, 32'h0);
        rd(IE, 32'h0);
        wr(`LSS_OFF_CTRL, 32'h1);
        rd(`LSS_OFF_CTRL, 32'h1);
        wr(LS, 32'h0);
        rd(LS, 32'h1000_0000);
        wr(SC, 32'hFFFF_FFFF);
        wait_msg(10'h3FF);
        cyc(3);
        // Sink still stalled, so the request must stand
        wait_msg(10'h3FF);
        msg_ready <= 1'b1;
        rd(SC, 32'h0001_FF80);
        rd(IS, 32'h4);
        wr(`LSS_OFF_CTRL, 32'h0);
        wr(LS, 32'h0);
        rd(LS, 32'h0);
        wr(SC, 32'hFFFF_FFFF);
        rd(SC, 32'hFFFB_FFFF);
        for (int s = 0; s < 4; s++) begin
            d = (32'(s) << 15) | (32'(8'h5A + 8'(s)) << 7);
            wr(SC, d);
            wait_msg({8'h5A + 8'(s), 2'(s)});
            rd(SC, d);
        end
        slot_implemented <= 1'b0;
        cyc(2);
        rd(SC, 32'h0);
        wr(SC, 32'h1234_5678);
        slot_implemented <= 1'b1;
        rd(SC, d);
        data_link_active <= 1'b1;
        wait_msg({8'h5D, 2'h3});
        rd(LS, 32'h2000_0000);
        dl_active_report_capable <= 1'b0;
        cyc(2);
        rd(LS, 32'h0);
        dl_active_report_capable <= 1'b1;
        trn(LSS_LT_CONFIG, 1'b0, DS, 1'b1);
        rd(LS, 32'h2800_0000);
        trn(LSS_LT_L0, 1'b0, DS, 1'b0);
        trn(LSS_LT_RECOVERY, 1'b0, DS, 1'b1);
        trn(LSS_LT_L0, 1'b1, DS, 1'b1);
        trn(LSS_LT_CONFIG, 1'b0, DS, 1'b1);
        trn(LSS_LT_L0, 1'b0, DS, 1'b0);
        trn(LSS_LT_CONFIG, 1'b0, UP, 1'b0);
        trn(LSS_LT_RECOVERY, 1'b0, LSS_PM_OTHER, 1'b0);
        trn(LSS_LT_L0, 1'b0, DS, 1'b0);
        wr(IC, 32'h7);
        wr(IE, 32'h3);
        rd(IC, 32'h0);
        bwt(5'h10, 2'b01);
        bwt(5'h08, 2'b01);
        bwt(5'h02, 2'b01);
        bwt(5'h04, 2'b10);
        bwt(5'h03, 2'b10);
        // Masked event must stay latched but quiet
        wr(IE, 32'h0);
        pulse(5'h04);
        check(32'(irq), 32'h0);
        rd(IS, 32'h2);
        wr(IE, 32'h3);
        cyc(2);
        check(32'(irq), 32'h1);
        wr(IC, 32'h2);
        cyc(2);
        check(32'(irq), 32'h0);
        wr(LS, 32'h8000_0000);
        bandwidth_notify_capable <= 1'b0;
        pulse(5'h10);
        rd(LS, 32'h2000_0000);
        bandwidth_notify_capable <= 1'b1;
        port_mode <= UP;
        pulse(5'h04);
        rd(LS, 32'h2000_0000);
        port_mode <= DS;
        // Second reset with the strap low and the link already up
        presetn <= 1'b0;
        common_clock_strap <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        cyc(1);
        wait_msg(10'h000);
        rd(LS, 32'h2000_0000);
        rd(12'h070, 32'h0);
        check(32'(rerr), 32'h1);
        finish_test();
    end

    initial begin
        cyc(20000);
        mismatches++;
        finish_test();
    end
endmodule : lss_link_slot_regs_tb_top
